// *** core/gpp_port.sv ***
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - one six-pin port, each pin with direction, latch and level read
// - direction one disables driver; zero drives the latch onto the pin
// - pin three is input-only; its direction bit always reads one
// - pin-level reads return pins; writes there go into the latch
// - latch writes equal pin-level writes; latch reads return stored latch
// - latch holds the latest write through either register
// - each latch or pin-level write stores the written bits under driven_mask; sampled pins never reach the latch
// - analog select disables digital input; digital reads return zero
// - analog select leaves digital output driving untouched
// - analog select bits come up set after reset, except pin three's, which stays clear
// - direction bits still steer drivers on analog pins
// - open-drain bit makes the pin sink only; clear means push-pull
// - slew bit selects limited edge rate; clear means full rate
// - threshold bit picks schmitt or ttl levels for reads
// - after reset pins carry the latch; peripherals arrive via routing
// - an enabled analog output overrides digital drive to high impedance
// - an enabled peripheral displaces the latch; the pin stays readable
// - a pin under i2c control is open-drain regardless of its bit
// - pull-up off while the direction bit is zero, except open-drain, where it follows output
// - with external reset enabled the input-only pin level reads one
module gpp_port #(
    parameter int unsigned pins = gpp_pkg::width
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe_n,
    output logic [5:0] pin_pull_up_en,
    output logic [5:0] pin_slew_limit,
    output logic [5:0] pin_schmitt_sel,
    input wire logic [5:0] periph_enable,
    input wire logic [5:0] periph_out,
    input wire logic [5:0] periph_oe_n,
    input wire logic [5:0] periph_i2c,
    input wire logic [5:0] analog_out_enable,
    input wire logic external_reset_pin_enable,
    output logic [5:0] digital_in
);
    if (pins != gpp_pkg::width) begin : g_check
        $error("gpp_port serves exactly six pins");
    end

    gpp_pkg::gpp_state_type state;
    gpp_pkg::gpp_state_type next_state;

    function automatic logic [5:0] fit(input logic [7:0] d);
        fit = d[5:0];
    endfunction : fit

    function automatic logic [7:0] widen(input logic [5:0] d);
        widen = {2'h0, d};
    endfunction : widen

    logic [5:0] level_view;
    logic [5:0] wr_val;
    logic [5:0] drv_en;
    logic [5:0] drv_val;
    logic [5:0] drv_od;

    always_comb begin
        next_state = state;
        // only the second stage is read; analog pins read zero
        level_view = state.sync2 & ~state.ctrl.analog;
        if (external_reset_pin_enable) begin
            level_view[gpp_pkg::input_only_index] = 1'b1;
        end
        // a byte write already names every bit, so the modify step
        // drops out: the store keeps only the written bits under driven_mask, and bit three stays zero
        wr_val = (level_view & ~gpp_pkg::driven_mask)
            | (fit(reg_wdata) & gpp_pkg::driven_mask);
        next_state.sync1 = pin_in;
        next_state.sync2 = state.sync1;
        next_state.rdata = 8'h00;
        if (reg_write) begin
            case (reg_addr)
                gpp_pkg::addr_pin_level,
                gpp_pkg::addr_latch: begin
                    next_state.ctrl.latch = wr_val & gpp_pkg::driven_mask;
                end
                gpp_pkg::addr_direction: begin
                    next_state.ctrl.direction = fit(reg_wdata)
                        | gpp_pkg::input_only_mask;
                end
                gpp_pkg::addr_analog: begin
                    next_state.ctrl.analog = fit(reg_wdata) & gpp_pkg::driven_mask;
                end
                gpp_pkg::addr_pull_up: begin
                    next_state.ctrl.pull_up = fit(reg_wdata);
                end
                gpp_pkg::addr_open_drain: begin
                    next_state.ctrl.open_drain = fit(reg_wdata) & gpp_pkg::driven_mask;
                end
                gpp_pkg::addr_slew: begin
                    next_state.ctrl.slew = fit(reg_wdata) & gpp_pkg::driven_mask;
                end
                gpp_pkg::addr_threshold: begin
                    // change only with peripherals off, or a false edge may appear
                    next_state.ctrl.threshold = fit(reg_wdata);
                end
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                gpp_pkg::addr_pin_level: next_state.rdata = widen(level_view);
                gpp_pkg::addr_latch: next_state.rdata = widen(state.ctrl.latch);
                gpp_pkg::addr_direction: next_state.rdata = widen(state.ctrl.direction);
                gpp_pkg::addr_analog: next_state.rdata = widen(state.ctrl.analog);
                gpp_pkg::addr_pull_up: next_state.rdata = widen(state.ctrl.pull_up);
                gpp_pkg::addr_open_drain: next_state.rdata = widen(state.ctrl.open_drain);
                gpp_pkg::addr_slew: next_state.rdata = widen(state.ctrl.slew);
                gpp_pkg::addr_threshold: next_state.rdata = widen(state.ctrl.threshold);
                default: next_state.rdata = 8'h00;
            endcase
        end
        // pad drive, taken from the next-state controls
        for (int i = 0; i < gpp_pkg::width; i++) begin
            if (periph_enable[i]) begin
                drv_en[i] = ~periph_oe_n[i];
                drv_val[i] = periph_out[i];
            end else begin
                drv_en[i] = ~next_state.ctrl.direction[i];
                drv_val[i] = next_state.ctrl.latch[i];
            end
            drv_od[i] = next_state.ctrl.open_drain[i]
                | (periph_enable[i] & periph_i2c[i]);
            if (analog_out_enable[i] || !gpp_pkg::driven_mask[i]) begin
                drv_en[i] = 1'b0;
            end
            // open drain releases the pin for a high
            if (drv_od[i] && drv_val[i]) begin
                drv_en[i] = 1'b0;
            end
            next_state.pad.oe_n[i] = ~drv_en[i];
            next_state.pad.out[i] = drv_od[i] ? 1'b0 : drv_val[i];
            if (i == gpp_pkg::input_only_index) begin
                next_state.pad.pull_up_en[i] = next_state.ctrl.pull_up[i]
                    | external_reset_pin_enable;
            end else if (drv_od[i] && !next_state.ctrl.direction[i]) begin
                next_state.pad.pull_up_en[i] = next_state.ctrl.pull_up[i] & drv_val[i];
            end else begin
                next_state.pad.pull_up_en[i] = next_state.ctrl.pull_up[i]
                    & next_state.ctrl.direction[i];
            end
            next_state.pad.slew_limit[i] = next_state.ctrl.slew[i];
            next_state.pad.schmitt_sel[i] = ~next_state.ctrl.threshold[i];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state.ctrl.direction <= gpp_pkg::rst_direction;
            state.ctrl.latch <= gpp_pkg::rst_latch;
            state.ctrl.analog <= gpp_pkg::rst_analog;
            state.ctrl.pull_up <= gpp_pkg::rst_pull_up;
            state.ctrl.open_drain <= gpp_pkg::rst_open_drain;
            state.ctrl.slew <= gpp_pkg::rst_slew;
            state.ctrl.threshold <= gpp_pkg::rst_threshold;
            state.pad.out <= 6'h00;
            state.pad.oe_n <= 6'h3f;
            state.pad.pull_up_en <= 6'h00;
            state.pad.slew_limit <= gpp_pkg::rst_slew;
            state.pad.schmitt_sel <= 6'h3f;
            state.sync1 <= 6'h00;
            state.sync2 <= 6'h00;
            state.rdata <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    logic [5:0] din_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            din_q <= 6'h00;
        end else begin
            din_q <= level_view;
        end
    end

    assign reg_rdata = state.rdata;
    assign pin_out = state.pad.out;
    assign pin_oe_n = state.pad.oe_n;
    assign pin_pull_up_en = state.pad.pull_up_en;
    assign pin_slew_limit = state.pad.slew_limit;
    assign pin_schmitt_sel = state.pad.schmitt_sel;
    assign digital_in = din_q;

    sequence s_dir_write;
        reg_write && reg_addr == gpp_pkg::addr_direction;
    endsequence

    sequence s_latch_write;
        reg_write && (reg_addr == gpp_pkg::addr_latch || reg_addr == gpp_pkg::addr_pin_level);
    endsequence

    a_input_only_dir: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state.ctrl.direction[gpp_pkg::input_only_index])
        else $error("input-only direction bit cleared");

    a_latch_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_latch_write |=> state.ctrl.latch == (fit($past(reg_wdata)) & gpp_pkg::driven_mask))
        else $error("latch did not take written value");

    a_dir_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_dir_write |=> state.ctrl.direction
            == (fit($past(reg_wdata)) | gpp_pkg::input_only_mask))
        else $error("direction did not take written value");

    a_latch_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_read && reg_addr == gpp_pkg::addr_latch && !reg_write
            |=> reg_rdata == widen($past(state.ctrl.latch)))
        else $error("latch readback wrong");

    a_analog_reads_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_read && reg_addr == gpp_pkg::addr_pin_level
            |=> (reg_rdata[5:0] & $past(state.ctrl.analog)) == 6'h00)
        else $error("analog pin read as one");

    a_input_no_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state.ctrl.direction[0] && !periph_enable[0] |=> pin_oe_n[0]
            || $past(reg_write))
        else $error("input pin driven");

    a_analog_out_hiz: assert property (@(posedge sys_clk) disable iff (!arst_n)
        analog_out_enable[1] |=> pin_oe_n[1])
        else $error("analog output did not release pin");

    a_od_no_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !pin_oe_n[2] && state.ctrl.open_drain[2] |-> !pin_out[2])
        else $error("open-drain pin drove high");

    a_i2c_no_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        periph_enable[4] && periph_i2c[4] |=> pin_oe_n[4] || !pin_out[4])
        else $error("i2c pin drove high");

    // strobes addressed to one register, reused by the checks below
    sequence s_read_at(logic [3:0] a);
        reg_read && reg_addr == a;
    endsequence

    sequence s_write_at(logic [3:0] a);
        reg_write && reg_addr == a;
    endsequence

    a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data left standing");

    a_rdata_top_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_rdata[7:6] == 2'h0)
        else $error("unused read bits set");

    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_read && reg_addr > gpp_pkg::addr_threshold |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_dir_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_read_at(gpp_pkg::addr_direction)
            |=> reg_rdata == widen($past(state.ctrl.direction)))
        else $error("direction readback wrong");

    a_level_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_read_at(gpp_pkg::addr_pin_level) |=> reg_rdata == widen($past(level_view)))
        else $error("pin level readback wrong");

    a_analog_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_write_at(gpp_pkg::addr_analog)
            |=> state.ctrl.analog == (fit($past(reg_wdata)) & gpp_pkg::driven_mask))
        else $error("analog select did not take written value");

    a_threshold_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_write_at(gpp_pkg::addr_threshold)
            |=> state.ctrl.threshold == fit($past(reg_wdata)))
        else $error("threshold did not take written value");

    a_dir_holds: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(reg_write && reg_addr == gpp_pkg::addr_direction)
            |=> $stable(state.ctrl.direction))
        else $error("direction changed without a write");

    a_latch_holds: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(reg_write && (reg_addr == gpp_pkg::addr_latch
            || reg_addr == gpp_pkg::addr_pin_level)) |=> $stable(state.ctrl.latch))
        else $error("latch changed without a write");

    a_latch_bit3_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state.ctrl.latch[gpp_pkg::input_only_index] == 1'b0)
        else $error("input-only latch bit set");

    a_analog_bit3_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state.ctrl.analog[gpp_pkg::input_only_index] == 1'b0)
        else $error("input-only analog bit set");

    a_od_bit3_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state.ctrl.open_drain[gpp_pkg::input_only_index] == 1'b0)
        else $error("input-only open-drain bit set");

    a_slew_bit3_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state.ctrl.slew[gpp_pkg::input_only_index] == 1'b0)
        else $error("input-only slew bit set");

    a_input_only_hiz: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pin_oe_n[gpp_pkg::input_only_index])
        else $error("input-only pin driven");

    a_slew_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pin_slew_limit == state.ctrl.slew)
        else $error("slew pad control differs from register");

    a_schmitt_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pin_schmitt_sel == ~state.ctrl.threshold)
        else $error("threshold pad control differs from register");

    a_od_never_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (pin_out & state.ctrl.open_drain) == 6'h00)
        else $error("open-drain pin output high");

    a_analog_out_all: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ($past(analog_out_enable) & ~pin_oe_n) == 6'h00)
        else $error("analog output pin still driven");

    a_latch_drives: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !state.ctrl.direction[5] && !state.ctrl.open_drain[5]
            && !$past(periph_enable[5]) && !$past(analog_out_enable[5])
            |-> !pin_oe_n[5] && pin_out[5] == state.ctrl.latch[5])
        else $error("output pin not driving latch");

    a_periph_drives: assert property (@(posedge sys_clk) disable iff (!arst_n)
        periph_enable[0] && !periph_i2c[0] && !analog_out_enable[0]
            && !next_state.ctrl.open_drain[0]
            |=> pin_out[0] == $past(periph_out[0])
            && pin_oe_n[0] == $past(periph_oe_n[0]))
        else $error("peripheral drive not on pin");

    a_pu_off_output: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !state.ctrl.direction[1] && !state.ctrl.open_drain[1] && !$past(periph_enable[1])
            |-> !pin_pull_up_en[1])
        else $error("pull-up on for push-pull output");

    a_pu_od_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !state.ctrl.direction[2] && state.ctrl.open_drain[2] && !$past(periph_enable[2])
            |-> pin_pull_up_en[2] == (state.ctrl.pull_up[2] & state.ctrl.latch[2]))
        else $error("open-drain pull-up does not follow output");

    a_ext_reset_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        external_reset_pin_enable |-> level_view[gpp_pkg::input_only_index])
        else $error("input-only pin not read as one");

    a_ext_reset_pull: assert property (@(posedge sys_clk) disable iff (!arst_n)
        external_reset_pin_enable |=> pin_pull_up_en[gpp_pkg::input_only_index])
        else $error("input-only pull-up off with external reset");

    a_din_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> digital_in == $past(level_view))
        else $error("digital input view stale");

    a_din_analog_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (digital_in & $past(state.ctrl.analog)) == 6'h00)
        else $error("analog pin seen as one by peripherals");
endmodule : gpp_port

// *** core/gpp_pkg.sv ***
package gpp_pkg;
    localparam int unsigned width = 6;
    localparam int unsigned addr_width = 4;
    localparam int unsigned data_width = 8;

    // register word addresses on the plain register port
    localparam logic [3:0] addr_pin_level = 4'h0;
    localparam logic [3:0] addr_latch = 4'h1;
    localparam logic [3:0] addr_direction = 4'h2;
    localparam logic [3:0] addr_analog = 4'h3;
    localparam logic [3:0] addr_pull_up = 4'h4;
    localparam logic [3:0] addr_open_drain = 4'h5;
    localparam logic [3:0] addr_slew = 4'h6;
    localparam logic [3:0] addr_threshold = 4'h7;

    // reset values of the control bits
    localparam logic [5:0] rst_direction = 6'h3f;
    localparam logic [5:0] rst_analog = 6'h37;
    localparam logic [5:0] rst_latch = 6'h00;
    localparam logic [5:0] rst_pull_up = 6'h00;
    localparam logic [5:0] rst_open_drain = 6'h00;
    localparam logic [5:0] rst_slew = 6'h37;
    localparam logic [5:0] rst_threshold = 6'h00;

    // the input-only pin and the mask of its neighbours that have drivers
    localparam int unsigned input_only_index = 3;
    localparam logic [5:0] input_only_mask = 6'h08;
    localparam logic [5:0] driven_mask = 6'h37;

    typedef struct packed {
        logic [5:0] direction;
        logic [5:0] latch;
        logic [5:0] analog;
        logic [5:0] pull_up;
        logic [5:0] open_drain;
        logic [5:0] slew;
        logic [5:0] threshold;
    } gpp_ctrl_type;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe_n;
        logic [5:0] pull_up_en;
        logic [5:0] slew_limit;
        logic [5:0] schmitt_sel;
    } gpp_pad_type;

    typedef struct packed {
        gpp_ctrl_type ctrl;
        gpp_pad_type pad;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [7:0] rdata;
    } gpp_state_type;
endpackage : gpp_pkg

// *** sim/gpp_pad_model.sv ***
`timescale 1ns/1ps
module gpp_pad_model (
    input wire logic sys_clk,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe_n,
    input wire logic [5:0] pin_pull_up_en,
    input wire logic [5:0] ext_en,
    input wire logic [5:0] ext_drive,
    output logic [5:0] pin_in
);
    // a floating pad wanders so a stale level never reads as valid
    logic [5:0] wander = 6'h15;
    always_ff @(posedge sys_clk) begin
        wander <= ~wander;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_drive[i];
            end else if (pin_pull_up_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = wander[i];
            end
        end
    end
endmodule : gpp_pad_model

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [5:0] pin_in, pin_out, pin_oe_n, pin_pull_up_en, pin_slew_limit, pin_schmitt_sel;
    logic [5:0] digital_in;
    logic [5:0] periph_enable = 6'h00;
    logic [5:0] periph_out = 6'h00;
    logic [5:0] periph_oe_n = 6'h3f;
    logic [5:0] periph_i2c = 6'h00;
    logic [5:0] analog_out_enable = 6'h00;
    logic external_reset_pin_enable = 1'b0;
    logic [5:0] ext_drive = 6'h08;
    int fails = 0;
    int checked = 0;
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h3f, 8'h37, 8'h00, 8'h00, 8'h37, 8'h00};

    gpp_port dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up_en(pin_pull_up_en), .pin_slew_limit(pin_slew_limit),
        .pin_schmitt_sel(pin_schmitt_sel), .periph_enable(periph_enable),
        .periph_out(periph_out), .periph_oe_n(periph_oe_n), .periph_i2c(periph_i2c),
        .analog_out_enable(analog_out_enable),
        .external_reset_pin_enable(external_reset_pin_enable), .digital_in(digital_in));

    // only the input-only pin is driven from outside; the rest float when released and not pulled up
    gpp_pad_model pads (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up_en(pin_pull_up_en), .ext_en(6'h08), .ext_drive(ext_drive),
        .pin_in(pin_in));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata & m, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    initial begin
        #500000;
        fails++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        chk("pin_oe_n", {2'h0, pin_oe_n}, 8'h3f);
        chk("pin_slew_limit", {2'h0, pin_slew_limit}, 8'h37);
        chk("pin_schmitt_sel", {2'h0, pin_schmitt_sel}, 8'h3f);
        for (int a = 1; a < 8; a++) rd(4'(a), rv[a]);
        rd(4'h8, 8'h00);
        $display("test reset done");
        wr(gpp_pkg::addr_latch, 8'h15);
        wr(gpp_pkg::addr_direction, 8'h00);
        chk("pin_out", {2'h0, pin_out}, 8'h15);
        chk("pin_oe_n", {2'h0, pin_oe_n}, 8'h08);
        rd(gpp_pkg::addr_direction, 8'h08);
        rd(gpp_pkg::addr_pin_level, 8'h08);
        wr(gpp_pkg::addr_analog, 8'h00);
        cyc(2);
        rd(gpp_pkg::addr_pin_level, 8'h1d);
        chk("digital_in", {2'h0, digital_in}, 8'h1d);
        $display("test direction done");
        wr(gpp_pkg::addr_pin_level, 8'h2a);
        cyc(2);
        rd(gpp_pkg::addr_latch, 8'h22);
        rd(gpp_pkg::addr_pin_level, 8'h2a);
        wr(gpp_pkg::addr_latch, 8'h11);
        rd(gpp_pkg::addr_latch, 8'h11);
        $display("test latch done");
        wr(gpp_pkg::addr_pull_up, 8'h3f);
        chk("pin_pull_up_en", {2'h0, pin_pull_up_en}, 8'h08);
        wr(gpp_pkg::addr_open_drain, 8'h3f);
        rd(gpp_pkg::addr_open_drain, 8'h37);
        chk("pin_oe_n", {2'h0, pin_oe_n}, 8'h19);
        chk("pin_out", {2'h0, pin_out}, 8'h00);
        chk("pin_pull_up_en", {2'h0, pin_pull_up_en}, 8'h19);
        wr(gpp_pkg::addr_open_drain, 8'h00);
        $display("test open drain done");
        @(posedge sys_clk);
        periph_enable <= 6'h01;
        periph_oe_n <= 6'h00;
        cyc(2);
        chk("pin_out0", {7'h0, pin_out[0]}, 8'h00);
        chk("pin_oe_n0", {7'h0, pin_oe_n[0]}, 8'h00);
        @(posedge sys_clk);
        periph_out <= 6'h01;
        periph_i2c <= 6'h01;
        cyc(2);
        chk("pin_oe_n0", {7'h0, pin_oe_n[0]}, 8'h01);
        @(posedge sys_clk);
        analog_out_enable <= 6'h10;
        cyc(2);
        chk("pin_oe_n4", {7'h0, pin_oe_n[4]}, 8'h01);
        $display("test peripheral done");
        // thresholds move only with every peripheral off
        @(posedge sys_clk);
        periph_enable <= 6'h00;
        wr(gpp_pkg::addr_threshold, 8'h3f);
        rd(gpp_pkg::addr_threshold, 8'h3f);
        chk("pin_schmitt_sel", {2'h0, pin_schmitt_sel}, 8'h00);
        wr(gpp_pkg::addr_slew, 8'h00);
        chk("pin_slew_limit", {2'h0, pin_slew_limit}, 8'h00);
        @(posedge sys_clk);
        ext_drive <= 6'h00;
        cyc(2);
        rd(gpp_pkg::addr_pin_level, 8'h00, 8'h08);
        @(posedge sys_clk);
        external_reset_pin_enable <= 1'b1;
        cyc(2);
        rd(gpp_pkg::addr_pin_level, 8'h08, 8'h08);
        $display("test pad controls done");
        @(posedge sys_clk);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        rd(gpp_pkg::addr_analog, 8'h37);
        rd(gpp_pkg::addr_latch, 8'h00);
        $display("test second reset done");
        finish_test;
    end
endmodule : tb_top
